// [hdl/ufc_pkg.sv]
// constants for the uart fifo control and dma ready block
`default_nettype none
package ufc_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_DATA       = 4'h0;
  localparam logic [3:0] OFS_FIFO_CTRL  = 4'h1;
  localparam logic [3:0] OFS_INT_STATUS = 4'h2;
  localparam logic [3:0] OFS_EVENTS     = 4'h3;
  localparam logic [3:0] OFS_EVENT_MASK = 4'h4;
  localparam logic [3:0] OFS_RX_LEVEL   = 4'h5;
  localparam logic [3:0] OFS_TX_LEVEL   = 4'h6;
  // fifo_control field positions
  localparam int FC_ENABLE   = 0;
  localparam int FC_RX_FLUSH = 1;
  localparam int FC_TX_FLUSH = 2;
  localparam int FC_DMA_MODE = 3;
  localparam int FC_TRIG_LO  = 6;
  // event bits
  localparam int EV_RX_TRIGGER = 0;
  localparam int EV_TX_EMPTY   = 1;
  localparam int EV_RX_OVERRUN = 2;
  localparam int EV_RX_TIMEOUT = 3;
  localparam int EV_BITS       = 4;
  // fifo geometry
  localparam int         DEPTH    = 16;
  localparam int         CNT_W    = 5;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_ONE  = 5'h01;
  // receive trigger levels per select code
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;
  // values after reset
  localparam logic [1:0] RST_TRIG_SEL = 2'h0;
  localparam logic       RST_DMA_MODE = 1'b0;
  localparam logic       RST_ENABLE   = 1'b0;
  localparam logic       RST_TX_REQ_N = 1'b0;
  localparam logic       RST_RX_REQ_N = 1'b1;
  localparam logic [3:0] RST_EVENTS   = 4'h0;
endpackage : ufc_pkg
`default_nettype wire

// [hdl/ufc_fifo_if.sv]
// signals between a byte fifo and its user
`default_nettype none
interface ufc_fifo_if;
  logic       push_valid;
  logic [7:0] push_data;
  logic       push_ready;
  logic       pop_ready;
  logic       pop_valid;
  logic [7:0] pop_data;
  logic       flush;
  logic       single;
  logic [4:0] count;
  modport fifo (input push_valid, push_data, pop_ready, flush, single,
                output push_ready, pop_valid, pop_data, count);
  modport user (output push_valid, push_data, pop_ready, flush, single,
                input push_ready, pop_valid, pop_data, count);
endinterface : ufc_fifo_if
`default_nettype wire

// [hdl/ufc_byte_fifo.sv]
// sixteen-entry byte fifo that shrinks to one entry in single mode
`default_nettype none
module ufc_byte_fifo
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // fifo port
  ufc_fifo_if.fifo q
);
  logic [7:0] mem [ufc_pkg::DEPTH];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [4:0] count;
  wire  [4:0] limit   = q.single ? ufc_pkg::CNT_ONE : ufc_pkg::CNT_FULL;
  wire        full    = (count >= limit);
  wire        do_push = q.push_valid && !full && !q.flush;
  wire        do_pop  = q.pop_ready && (count != 5'h00) && !q.flush;

  assign q.push_ready = !full;
  assign q.pop_valid  = (count != 5'h00);
  assign q.pop_data   = mem[rd_ptr];
  assign q.count      = count;

  genvar i;
  generate
    for (i = 0; i < ufc_pkg::DEPTH; i++)
    begin : g_entry
      always_ff @(posedge clock)
      begin
        if (do_push && (wr_ptr == 4'(i)))
          mem[i] <= q.push_data;
      end
    end
  endgenerate

  // flush clears pointers and count only, never the memory
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count  <= 5'h00;
    end
    else if (q.flush)
    begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count  <= 5'h00;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 4'h1;
      if (do_pop)
        rd_ptr <= rd_ptr + 4'h1;
      if (do_push && !do_pop)
        count <= count + 5'h01;
      else if (do_pop && !do_push)
        count <= count - 5'h01;
    end
  end
endmodule // ufc_byte_fifo
`default_nettype wire

// [hdl/ufc_dma_ready.sv]
// fifo control, trigger levels, dma ready pins and events of one uart channel
`default_nettype none
module ufc_dma_ready
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output var  logic [7:0] reg_rdata,
  // transmit shifter side
  input  wire logic       tx_shifter_idle,
  output var  logic       tx_load,
  output var  logic [7:0] tx_load_data,
  // receive shifter side
  input  wire logic       rx_byte_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_timeout,
  // dma request pins and interrupt
  output var  logic       tx_dma_request_n,
  output var  logic       rx_dma_request_n,
  output var  logic       irq
);
  ufc_fifo_if tx_q ();
  ufc_fifo_if rx_q ();

  logic       fifo_enable;
  logic       dma_mode;
  logic [1:0] rx_threshold_select;
  logic       tx_queue_flush;
  logic       rx_queue_flush;
  logic       rx_mode1_hold;
  logic       rx_at_trigger_q;
  logic       tx_empty_q;
  logic [3:0] events;
  logic [3:0] event_mask;

  // register decode
  wire wr_data   = reg_write && (reg_addr == ufc_pkg::OFS_DATA);
  wire wr_fc     = reg_write && (reg_addr == ufc_pkg::OFS_FIFO_CTRL);
  wire wr_events = reg_write && (reg_addr == ufc_pkg::OFS_EVENTS);
  wire wr_mask   = reg_write && (reg_addr == ufc_pkg::OFS_EVENT_MASK);
  wire rd_data   = reg_read && (reg_addr == ufc_pkg::OFS_DATA);

  wire fc_accept = wr_fc && reg_wdata[ufc_pkg::FC_ENABLE];
  wire fc_toggle = wr_fc && (reg_wdata[ufc_pkg::FC_ENABLE] != fifo_enable);

  wire [4:0] trig_level =
    (rx_threshold_select == 2'h0) ? ufc_pkg::TRIG_L0 :
    (rx_threshold_select == 2'h1) ? ufc_pkg::TRIG_L1 :
    (rx_threshold_select == 2'h2) ? ufc_pkg::TRIG_L2 : ufc_pkg::TRIG_L3;

  wire rx_at_trigger = fifo_enable && (rx_q.count >= trig_level);
  wire mode1         = fifo_enable && dma_mode;
  wire tx_take       = tx_shifter_idle && !tx_load && tx_q.pop_valid;
  wire rx_overrun    = rx_byte_valid && !rx_q.push_ready;
  wire tx_empty      = (tx_q.count == 5'h00) && !tx_load;

  wire tx_req_m0_n = (tx_q.count != 5'h00);
  wire tx_req_m1_n = (tx_q.count == ufc_pkg::CNT_FULL);
  wire rx_req_m0_n = (rx_q.count == 5'h00);
  // mode 1 sets on trigger or timeout
  wire rx_m1_set   = rx_at_trigger || (rx_timeout && (rx_q.count != 5'h00));
  wire next_rx_m1_hold = (rx_q.count == 5'h00) ? rx_m1_set : (rx_mode1_hold || rx_m1_set);

  wire [3:0] ev_set;
  assign ev_set[ufc_pkg::EV_RX_TRIGGER] = rx_at_trigger && !rx_at_trigger_q;
  assign ev_set[ufc_pkg::EV_TX_EMPTY]   = tx_empty && !tx_empty_q;
  assign ev_set[ufc_pkg::EV_RX_OVERRUN] = rx_overrun;
  assign ev_set[ufc_pkg::EV_RX_TIMEOUT] = rx_timeout;
  // set wins over a one written in the same cycle
  wire [3:0] next_events = (events & ~(wr_events ? reg_wdata[3:0] : 4'h0)) | ev_set;
  wire [3:0] next_mask   = wr_mask ? reg_wdata[3:0] : event_mask;

  // unused bits and flush bits read zero
  wire [7:0] fc_view = {rx_threshold_select, 2'b00, dma_mode, 2'b00, fifo_enable};
  wire [7:0] isr_view = {fifo_enable, fifo_enable, 3'b000, rx_at_trigger, 1'b0,
                         !rx_at_trigger};
  wire [7:0] rd_mux =
    (reg_addr == ufc_pkg::OFS_DATA)       ? rx_q.pop_data :
    (reg_addr == ufc_pkg::OFS_FIFO_CTRL)  ? fc_view :
    (reg_addr == ufc_pkg::OFS_INT_STATUS) ? isr_view :
    (reg_addr == ufc_pkg::OFS_EVENTS)     ? {4'h0, events} :
    (reg_addr == ufc_pkg::OFS_EVENT_MASK) ? {4'h0, event_mask} :
    (reg_addr == ufc_pkg::OFS_RX_LEVEL)   ? {3'b000, rx_q.count} :
    (reg_addr == ufc_pkg::OFS_TX_LEVEL)   ? {3'b000, tx_q.count} : 8'h00;

  // fifo connections
  assign tx_q.push_valid = wr_data;
  assign tx_q.push_data  = reg_wdata;
  assign tx_q.pop_ready  = tx_take;
  assign tx_q.flush      = tx_queue_flush;
  assign tx_q.single     = !fifo_enable;
  assign rx_q.push_valid = rx_byte_valid;
  assign rx_q.push_data  = rx_byte;
  assign rx_q.pop_ready  = rd_data;
  assign rx_q.flush      = rx_queue_flush;
  assign rx_q.single     = !fifo_enable;

  ufc_byte_fifo u_tx_fifo
  (
    .clock (clock),
    .rst_n (rst_n),
    .q     (tx_q.fifo)
  );

  ufc_byte_fifo u_rx_fifo
  (
    .clock (clock),
    .rst_n (rst_n),
    .q     (rx_q.fifo)
  );

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifo_enable         <= ufc_pkg::RST_ENABLE;
      dma_mode            <= ufc_pkg::RST_DMA_MODE;
      rx_threshold_select <= ufc_pkg::RST_TRIG_SEL;
    end
    else if (wr_fc)
    begin
      fifo_enable <= reg_wdata[ufc_pkg::FC_ENABLE];
      if (fc_accept)
      begin
        dma_mode            <= reg_wdata[ufc_pkg::FC_DMA_MODE];
        rx_threshold_select <= reg_wdata[ufc_pkg::FC_TRIG_LO +: 2];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_queue_flush <= 1'b0;
      rx_queue_flush <= 1'b0;
    end
    else
    begin
      tx_queue_flush <= (fc_accept && reg_wdata[ufc_pkg::FC_TX_FLUSH]) || fc_toggle;
      rx_queue_flush <= (fc_accept && reg_wdata[ufc_pkg::FC_RX_FLUSH]) || fc_toggle;
    end
  end

  // hand bytes to the transmit shifter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_load      <= 1'b0;
      tx_load_data <= 8'h00;
    end
    else
    begin
      tx_load <= tx_take && !tx_queue_flush;
      if (tx_take)
        tx_load_data <= tx_q.pop_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_dma_request_n <= ufc_pkg::RST_TX_REQ_N;
      rx_dma_request_n <= ufc_pkg::RST_RX_REQ_N;
      rx_mode1_hold    <= 1'b0;
    end
    else
    begin
      rx_mode1_hold    <= next_rx_m1_hold;
      tx_dma_request_n <= mode1 ? tx_req_m1_n : tx_req_m0_n;
      rx_dma_request_n <= mode1 ? !next_rx_m1_hold : rx_req_m0_n;
    end
  end

  // sticky events, mask, interrupt and read data
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      events          <= ufc_pkg::RST_EVENTS;
      event_mask      <= ufc_pkg::RST_EVENTS;
      rx_at_trigger_q <= 1'b0;
      tx_empty_q      <= 1'b1;
      irq             <= 1'b0;
      reg_rdata       <= 8'h00;
    end
    else
    begin
      events          <= next_events;
      event_mask      <= next_mask;
      rx_at_trigger_q <= rx_at_trigger;
      tx_empty_q      <= tx_empty;
      irq             <= |(next_events & next_mask);
      reg_rdata       <= reg_read ? rd_mux : 8'h00;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_fc_write_flush_tx;
    wr_fc && reg_wdata[ufc_pkg::FC_ENABLE] && reg_wdata[ufc_pkg::FC_TX_FLUSH];
  endsequence
  sequence s_fc_write_flush_rx;
    wr_fc && reg_wdata[ufc_pkg::FC_ENABLE] && reg_wdata[ufc_pkg::FC_RX_FLUSH];
  endsequence

  property p_trigger_irq;
    fifo_enable && event_mask[ufc_pkg::EV_RX_TRIGGER] && !wr_events && !wr_mask
      && !rx_at_trigger_q && (rx_q.count == trig_level) |=> irq;
  endproperty
  a_trigger_irq : assert property (p_trigger_irq)
    else $error("receive trigger did not raise interrupt");

  property p_trig_decode;
    fifo_enable && rx_threshold_select == 2'h3 && rx_q.count == 5'h0d
      |-> !rx_at_trigger;
  endproperty
  a_trig_decode : assert property (p_trig_decode)
    else $error("trigger level 14 decoded wrongly");

  property p_unused_zero;
    reg_read && reg_addr == ufc_pkg::OFS_FIFO_CTRL |=> reg_rdata[5:4] == 2'b00;
  endproperty
  a_unused_zero : assert property (p_unused_zero)
    else $error("unused control bits read nonzero");

  property p_dma_mode;
    fc_accept |=> dma_mode == $past(reg_wdata[ufc_pkg::FC_DMA_MODE]);
  endproperty
  a_dma_mode : assert property (p_dma_mode)
    else $error("dma mode not taken from bit 3");

  property p_tx_m0;
    !mode1 |=> tx_dma_request_n == ($past(tx_q.count) != 5'h00);
  endproperty
  a_tx_m0 : assert property (p_tx_m0)
    else $error("mode 0 transmit ready wrong");

  property p_rx_m0;
    !mode1 |=> rx_dma_request_n == ($past(rx_q.count) == 5'h00);
  endproperty
  a_rx_m0 : assert property (p_rx_m0)
    else $error("mode 0 receive ready wrong");

  property p_tx_m1;
    mode1 |=> tx_dma_request_n == ($past(tx_q.count) == ufc_pkg::CNT_FULL);
  endproperty
  a_tx_m1 : assert property (p_tx_m1)
    else $error("mode 1 transmit ready wrong");

  property p_rx_m1;
    mode1 && rx_at_trigger |=> !rx_dma_request_n;
  endproperty
  a_rx_m1 : assert property (p_rx_m1)
    else $error("mode 1 receive ready not asserted at trigger");

  property p_tx_flush;
    s_fc_write_flush_tx |=> tx_queue_flush ##1 (tx_q.count == 5'h00);
  endproperty
  a_tx_flush : assert property (p_tx_flush)
    else $error("transmit flush did not empty fifo");

  property p_rx_flush;
    s_fc_write_flush_rx |=> rx_queue_flush ##1 (rx_q.count == 5'h00);
  endproperty
  a_rx_flush : assert property (p_rx_flush)
    else $error("receive flush did not empty fifo");

  property p_ignore;
    wr_fc && !reg_wdata[ufc_pkg::FC_ENABLE]
      |=> $stable(dma_mode) && $stable(rx_threshold_select) && !fifo_enable;
  endproperty
  a_ignore : assert property (p_ignore)
    else $error("control bits changed with enable zero");

  property p_withdraw;
    reg_read && reg_addr == ufc_pkg::OFS_INT_STATUS && rx_q.count < trig_level
      |=> !reg_rdata[2] && reg_rdata[0];
  endproperty
  a_withdraw : assert property (p_withdraw)
    else $error("receive interrupt held below trigger");

  property p_isr_enabled;
    reg_read && reg_addr == ufc_pkg::OFS_INT_STATUS
      |=> reg_rdata[7:6] == {2{$past(fifo_enable)}};
  endproperty
  a_isr_enabled : assert property (p_isr_enabled)
    else $error("status bits 7:6 do not show enable");

  property p_single;
    !fifo_enable && !$past(fifo_enable) |-> rx_q.count <= ufc_pkg::CNT_ONE;
  endproperty
  a_single : assert property (p_single)
    else $error("disabled fifo holds more than one byte");
endmodule // ufc_dma_ready
`default_nettype wire

// [test/ufc_shifter_model.sv]
// transmit and receive shifter stand-in for the fifo control block
`default_nettype none
module ufc_shifter_model
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // transmit shifter
  input  wire logic       stall,
  input  wire logic       tx_load,
  output var  logic       tx_shifter_idle,
  // receive shifter
  output var  logic       rx_byte_valid,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] busy;
  // a loaded byte keeps the shifter away for a few cycles, idle drops on the clock edge that samples tx_load high
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      busy <= 3'h0;
    else if (tx_load)
      busy <= 3'h5;
    else if (busy != 3'h0)
      busy <= busy - 3'h1;
  assign tx_shifter_idle = !stall && (busy == 3'h0);
  initial
  begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'h5a;
    rx_timeout = 1'b0;
  end
  // one received byte; the data line shows junk outside the pulse
  task automatic send(input logic [7:0] b);
    @(posedge clock);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clock);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~b;
  endtask
  task automatic pulse_timeout();
    @(posedge clock);
    rx_timeout <= 1'b1;
    @(posedge clock);
    rx_timeout <= 1'b0;
  endtask
endmodule // ufc_shifter_model
`default_nettype wire

// [test/test_uart_fifo_control_dma_ready.sv]
// self-checking bench for the uart fifo control and dma ready block
`default_nettype none
module test_uart_fifo_control_dma_ready;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock;
  logic       rst_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  logic       stall;
  wire  [7:0] reg_rdata;
  wire        tx_shifter_idle;
  wire        tx_load;
  wire  [7:0] tx_load_data;
  wire        rx_byte_valid;
  wire  [7:0] rx_byte;
  wire        rx_timeout;
  wire        tx_dma_request_n;
  wire        rx_dma_request_n;
  wire        irq;
  int         mismatches;
  int         checks_done;
  int         cycles;
  int         seed;
  int         loads;
  int         lvls[4] = '{1, 4, 8, 14};
  logic [7:0] v;
  logic [7:0] rxq[$];

  ufc_dma_ready u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tx_shifter_idle(tx_shifter_idle), .tx_load(tx_load),
    .tx_load_data(tx_load_data), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_timeout(rx_timeout), .tx_dma_request_n(tx_dma_request_n),
    .rx_dma_request_n(rx_dma_request_n), .irq(irq));
  ufc_shifter_model u_far (.clock(clock), .rst_n(rst_n), .stall(stall), .tx_load(tx_load),
    .tx_shifter_idle(tx_shifter_idle), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_timeout(rx_timeout));

  always #10 clock = ~clock;

  // count bytes handed to the transmit shifter
  always @(posedge clock)
  begin
    if (tx_load)
      loads <= loads + 1;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    rd(a, d);
    chk(n, d, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic pins(input logic t, input logic r);
    chk("tx_dma_request_n", {7'h0, tx_dma_request_n}, {7'h0, t});
    chk("rx_dma_request_n", {7'h0, rx_dma_request_n}, {7'h0, r});
  endtask
  task automatic rx_in();
    v = 8'($random(seed));
    u_far.send(v);
    if (rxq.size() < 16)
      rxq.push_back(v);
  endtask

  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    stall = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    loads = 0;
    seed = 32'h2d48fc53;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rdchk(ufc_pkg::OFS_FIFO_CTRL, 8'h00, "fifo_control");
    rdchk(ufc_pkg::OFS_INT_STATUS, 8'h01, "interrupt_status");
    pins(1'b0, 1'b1);
    // fifos off: one holding byte, the second one overruns
    rx_in();
    rxq.delete();
    rxq.push_back(v);
    rx_in();
    settle();
    pins(1'b0, 1'b0);
    rdchk(ufc_pkg::OFS_RX_LEVEL, 8'h01, "rx_level");
    rd(ufc_pkg::OFS_EVENTS, v);
    chk("overrun", v & 8'h04, 8'h04);
    rdchk(ufc_pkg::OFS_DATA, rxq.pop_front(), "rx_data");
    settle();
    pins(1'b0, 1'b1);
    // every trigger code, interrupt status set at the level and dropped below it
    for (int t = 0; t < 4; t++)
    begin
      wr(ufc_pkg::OFS_FIFO_CTRL, {t[1:0], 6'h07});
      rxq.delete();
      rdchk(ufc_pkg::OFS_FIFO_CTRL, {t[1:0], 6'h01}, "fifo_control");
      for (int i = 1; i < lvls[t]; i++)
        rx_in();
      settle();
      rdchk(ufc_pkg::OFS_INT_STATUS, 8'hc1, "interrupt_status");
      rx_in();
      settle();
      rdchk(ufc_pkg::OFS_INT_STATUS, 8'hc4, "interrupt_status");
      rdchk(ufc_pkg::OFS_DATA, rxq.pop_front(), "rx_data");
      settle();
      rdchk(ufc_pkg::OFS_INT_STATUS, 8'hc1, "interrupt_status");
    end
    // keeps filling past the trigger until full
    repeat (4) rx_in();
    settle();
    rdchk(ufc_pkg::OFS_RX_LEVEL, 8'h10, "rx_level");
    wr(ufc_pkg::OFS_FIFO_CTRL, 8'h49);
    settle();
    pins(1'b0, 1'b0);
    while (rxq.size() > 1)
      rdchk(ufc_pkg::OFS_DATA, rxq.pop_front(), "rx_data");
    settle();
    pins(1'b0, 1'b0);
    rdchk(ufc_pkg::OFS_DATA, rxq.pop_front(), "rx_data");
    settle();
    pins(1'b0, 1'b1);
    rx_in();
    settle();
    pins(1'b0, 1'b1);
    u_far.pulse_timeout();
    settle();
    pins(1'b0, 1'b0);
    rdchk(ufc_pkg::OFS_DATA, rxq.pop_front(), "rx_data");
    settle();
    pins(1'b0, 1'b1);
    // mode 1 transmit: high only when all sixteen are taken, then flushed
    @(posedge clock);
    stall <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      wr(ufc_pkg::OFS_DATA, 8'($random(seed)));
      if (i == 14)
      begin
        settle();
        pins(1'b0, 1'b1);
      end
    end
    settle();
    pins(1'b1, 1'b1);
    rdchk(ufc_pkg::OFS_TX_LEVEL, 8'h10, "tx_level");
    wr(ufc_pkg::OFS_FIFO_CTRL, 8'h4d);
    settle();
    rdchk(ufc_pkg::OFS_TX_LEVEL, 8'h00, "tx_level");
    rdchk(ufc_pkg::OFS_FIFO_CTRL, 8'h49, "fifo_control");
    pins(1'b0, 1'b1);
    // mode 0 transmit, then the tx empty event through mask and clear
    wr(ufc_pkg::OFS_FIFO_CTRL, 8'h41);
    wr(ufc_pkg::OFS_EVENT_MASK, 8'h00);
    wr(ufc_pkg::OFS_EVENTS, 8'h0f);
    v = 8'($random(seed));
    wr(ufc_pkg::OFS_DATA, v);
    settle();
    pins(1'b1, 1'b1);
    @(posedge clock);
    stall <= 1'b0;
    settle();
    chk("tx_load_data", tx_load_data, v);
    chk("tx_load", 8'(loads), 8'h01);
    pins(1'b0, 1'b1);
    chk("irq", {7'h0, irq}, 8'h00);
    wr(ufc_pkg::OFS_EVENT_MASK, 8'h02);
    settle();
    chk("irq", {7'h0, irq}, 8'h01);
    wr(ufc_pkg::OFS_EVENTS, 8'h02);
    settle();
    chk("irq", {7'h0, irq}, 8'h00);
    // a write without enable only turns the fifos off
    wr(ufc_pkg::OFS_FIFO_CTRL, 8'hc8);
    rdchk(ufc_pkg::OFS_FIFO_CTRL, 8'h40, "fifo_control");
    rdchk(ufc_pkg::OFS_INT_STATUS, 8'h01, "interrupt_status");
    rdchk(4'hf, 8'h00, "unmapped");
    // receive trigger event through the mask to the interrupt pin
    wr(ufc_pkg::OFS_FIFO_CTRL, 8'h01);
    wr(ufc_pkg::OFS_EVENTS, 8'h0f);
    wr(ufc_pkg::OFS_EVENT_MASK, 8'h01);
    rx_in();
    settle();
    chk("irq", {7'h0, irq}, 8'h01);
    rdchk(ufc_pkg::OFS_INT_STATUS, 8'hc4, "interrupt_status");
    rdchk(ufc_pkg::OFS_DATA, rxq.pop_front(), "rx_data");
    end_of_test();
  end
endmodule // test_uart_fifo_control_dma_ready
`default_nettype wire
